/* usr_pkg.sv */
// Purpose: Shared constants and types of the serial receiver with SPI mode.
// Assumes: Used as usr_pkg::name, never imported.
// Notes: Behaviour summary follows.
// Behaviour
// - Frame starts on valid low start bit, bits sampled per mode, ends at first stop.
// - Nine-bit characters keep the ninth bit apart in rx_ninth_bit.
// - Receive buffer holds two entries; error flags travel with their word.
// - Receive complete flag is high while the buffer holds unread data.
// - Interrupt follows the complete flag when both enables are set.
// - Receiver disable stops at once, flushes buffer, clears flag, frees pin.
// - Frame error is 1 when first stop bit was low, else 0.
// - Overrun sets when buffer full and a new word arrives; read clears it.
// - With parity on, mismatch between computed and received parity flags the word.
// - Parity error reads zero when parity is disabled.
// - Async oversampling is 16x, or 8x in double speed.
// - After falling edge, majority of centre samples must be low; resync each frame.
// - Each data bit is a majority vote of centre samples, shifted in order.
// - Stop bit accepted on two of three high, else frame error; back to idle.
// - Mode field 11 selects SPI; select is input for slave, optional master output.
// - Polarity and phase select four formats; data changes on opposite edge.
// - Phase 0: slave drives first bit at select low; sample first edge.
// - Phase 1: first edge shifts out, second samples, third shifts next.
// - Phase 1: select may stay low across transfers.
// - Master transfer starts on data write even with transmitter disabled.
// - One start, five to nine data bits LSB first, parity option, idle high.
// - Even parity is XOR of data bits, odd parity its inverse.
`default_nettype none
package usr_pkg;
	localparam logic [1:0]  MODE_ASYNC = 2'h0;
	localparam logic [1:0]  MODE_SPI   = 2'h3;
	localparam logic [2:0]  SIZE_NINE  = 3'h7;
	localparam logic [4:0]  OS_NORM    = 5'h10;
	localparam logic [4:0]  OS_DBL     = 5'h08;
	localparam logic [3:0]  CTR_NORM   = 4'h8;
	localparam logic [3:0]  CTR_DBL    = 4'h4;
	localparam logic [1:0]  BUF_DEPTH  = 2'h2;
	localparam logic [3:0]  SPI_LAST   = 4'hf;
	localparam logic [10:0] ENTRY_RST  = 11'h000;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_DATA  = 3'h2,
		ST_PAR   = 3'h3,
		ST_STOP  = 3'h4
	} usr_st_t;
endpackage
`default_nettype wire

/* usr_rx.sv */
// Purpose: Serial receive path with async/sync UART and SPI master/slave.
// Assumes: Config inputs are quasi-static while a frame or transfer runs.
// Notes: SPI slave logic runs on the pin clock; words cross by toggle.
`timescale 1ns/10ps
`default_nettype none
module usr_rx (
	input  wire logic       core_clk,             // System clock
	input  wire logic       reset,                // Sync reset, high
	input  wire logic [1:0] op_mode_field,        // 00 async, 01 sync, 11 SPI
	input  wire logic [2:0] char_size_sel,        // 0..3 five..eight, 7 nine
	input  wire logic       parity_enable_bit,    // Parity check on
	input  wire logic       parity_odd_sel,       // Odd parity
	input  wire logic       double_speed_sel,     // 8x oversampling
	input  wire logic       clk_polarity_bit,     // Clock idle level
	input  wire logic       clk_phase_bit,        // Clock phase
	input  wire logic       spi_master_sel,       // SPI master
	input  wire logic       select_output_ctrl,   // 0 lets master drive select
	input  wire logic       rx_enable_bit,        // Receiver on
	input  wire logic       rx_complete_irq_en,   // Interrupt enable
	input  wire logic       global_irq_en,        // Global enable
	input  wire logic [7:0] baud_div,             // Tick divider minus one
	input  wire logic       data_wr,              // Data write strobe
	input  wire logic [7:0] wr_data,              // Data written
	input  wire logic       data_rd,              // Data read strobe, pops
	input  wire logic       serial_in_pin,        // UART in, master data in
	input  wire logic       serial_clock_in,      // Serial clock pin in
	output logic            serial_clock_out,     // Master clock out
	output logic            serial_clock_oe,      // Clock drive enable
	input  wire logic       slave_select_n_in,    // Select pin in, low
	output logic            slave_select_n_out,   // Master select out, low
	output logic            slave_select_oe,      // Select drive enable
	input  wire logic       spi_master_out_in,    // Slave data in
	output logic            spi_master_out_out,   // Master data out
	output logic            spi_master_out_oe,    // Master data enable
	output logic            spi_master_in_out,    // Slave data out
	output logic            spi_master_in_oe,     // Slave data enable
	output logic            rx_pin_claim,         // Input pin owned
	output logic [7:0]      serial_data_reg,      // Oldest byte
	output logic            rx_ninth_bit,         // Oldest ninth bit
	output logic            frame_err_flag,       // Oldest frame error
	output logic            parity_err_flag,      // Oldest parity error
	output logic            overrun_flag,         // Word lost
	output logic            rx_complete_flag,     // Unread data
	output logic            rx_irq,               // Receive interrupt
	output logic            tx_buffer_empty_flag  // Write may start
);
	usr_pkg::usr_st_t st, next_st;
	logic [7:0] bd_cnt, next_bd;
	logic [3:0] os_cnt, next_os, nb, next_nb, ctr, nbits;
	logic [4:0] os_len;
	logic [1:0] smp, next_smp;
	logic [8:0] sh, next_sh, uart_word, push_word;
	logic       par, next_par, perr, next_perr, u_push;
	logic       rx_s1, rx_s2, rx_s3, ck_s1, ck_s2, ck_s3, tg_s1, tg_s2, tg_s3;
	logic       tick, fall, ck_edge, vote, bit_ev, bit_val, async_md, uart_on;
	logic       m_on, m_busy, next_mbusy, m_ph, next_mph, m_push, next_mpush;
	logic [3:0] m_edge, next_medge;
	logic [7:0] m_div, next_mdiv, m_tx, next_mtx, m_rx, next_mrx, tx_hold;
	logic       slave_on, push, push_fe, push_pe, pop, ovr, next_ovr;
	logic [1:0] cnt, next_cnt;
	logic [10:0] rbuf [0:1];
	logic [10:0] next_rbuf [0:1];
	logic       link_clk, link_clr, lk_tog, lk_tbit;
	logic [2:0] lk_cnt, lk_tidx;
	logic [6:0] lk_sh;
	logic [7:0] lk_word;

	// Pin inputs pass two flops; third flop only feeds edge detectors
	always_ff @(posedge core_clk)
	begin
		rx_s1 <= serial_in_pin;
		rx_s2 <= rx_s1;
		rx_s3 <= rx_s2;
		ck_s1 <= serial_clock_in;
		ck_s2 <= ck_s1;
		ck_s3 <= ck_s2;
		tg_s1 <= lk_tog;
		tg_s2 <= tg_s1;
		tg_s3 <= tg_s2;
	end

	// Receiver timing and bit events
	assign async_md = (op_mode_field == usr_pkg::MODE_ASYNC);
	assign uart_on  = rx_enable_bit && (op_mode_field != usr_pkg::MODE_SPI);
	assign os_len   = double_speed_sel ? usr_pkg::OS_DBL : usr_pkg::OS_NORM;
	assign ctr      = double_speed_sel ? usr_pkg::CTR_DBL : usr_pkg::CTR_NORM;
	assign tick     = (bd_cnt == baud_div);
	assign fall     = rx_s3 && !rx_s2;
	assign ck_edge  = (ck_s2 ^ ck_s3) && (ck_s2 == clk_polarity_bit);
	assign vote     = (smp[0] & smp[1]) | (smp[0] & rx_s2) | (smp[1] & rx_s2);
	assign bit_val  = async_md ? vote : rx_s2;
	assign bit_ev   = uart_on && (async_md ? (st != usr_pkg::ST_IDLE && tick && os_cnt == ctr + 4'h1) : ck_edge);

	// Data bits per character and LSB-first alignment
	always_comb
	begin
		case (char_size_sel)
			3'h0:    begin nbits = 4'h5; uart_word = {4'h0, sh[8:4]}; end
			3'h1:    begin nbits = 4'h6; uart_word = {3'h0, sh[8:3]}; end
			3'h2:    begin nbits = 4'h7; uart_word = {2'h0, sh[8:2]}; end
			usr_pkg::SIZE_NINE: begin nbits = 4'h9; uart_word = sh; end
			default: begin nbits = 4'h8; uart_word = {1'b0, sh[8:1]}; end
		endcase
	end

	// Frame state machine
	always_comb
	begin
		next_st = st;
		next_os = os_cnt;
		next_bd = tick ? 8'h00 : bd_cnt + 8'h01;
		next_smp = smp;
		next_nb = nb;
		next_sh = sh;
		next_par = par;
		next_perr = perr;
		u_push = 1'b0;
		if (tick)
		begin
			next_os = ({1'b0, os_cnt} == os_len - 5'h01) ? 4'h0 : os_cnt + 4'h1;
			if (os_cnt == ctr - 4'h1)
				next_smp[0] = rx_s2;
			if (os_cnt == ctr)
				next_smp[1] = rx_s2;
		end
		case (st)
			usr_pkg::ST_IDLE:
				if (async_md && fall)
				begin
					// Restart bit timing at each start edge so drift never carries across frames
					next_st = usr_pkg::ST_START;
					next_os = 4'h0;
					next_bd = 8'h00;
				end
				else if (bit_ev && !bit_val)
				begin
					next_st = usr_pkg::ST_DATA;
					next_nb = 4'h0;
					next_par = 1'b0;
					next_perr = 1'b0;
				end
			usr_pkg::ST_START:
				if (bit_ev)
				begin
					next_st = bit_val ? usr_pkg::ST_IDLE : usr_pkg::ST_DATA;
					next_nb = 4'h0;
					next_par = 1'b0;
					next_perr = 1'b0;
				end
			usr_pkg::ST_DATA:
				if (bit_ev)
				begin
					next_sh = {bit_val, sh[8:1]};
					next_par = par ^ bit_val;
					next_nb = nb + 4'h1;
					if (nb == nbits - 4'h1)
						next_st = parity_enable_bit ? usr_pkg::ST_PAR : usr_pkg::ST_STOP;
				end
			usr_pkg::ST_PAR:
				if (bit_ev)
				begin
					next_perr = bit_val ^ par ^ parity_odd_sel;
					next_st = usr_pkg::ST_STOP;
				end
			usr_pkg::ST_STOP:
				if (bit_ev)
				begin
					// Second stop bit is never waited for
					u_push = 1'b1;
					next_st = usr_pkg::ST_IDLE;
				end
			default: next_st = usr_pkg::ST_IDLE;
		endcase
		if (!uart_on)
			next_st = usr_pkg::ST_IDLE;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st <= usr_pkg::ST_IDLE;
			bd_cnt <= 8'h00;
			os_cnt <= 4'h0;
			smp <= 2'h0;
			nb <= 4'h0;
			sh <= 9'h000;
			par <= 1'b0;
			perr <= 1'b0;
		end
		else
		begin
			st <= next_st;
			bd_cnt <= next_bd;
			os_cnt <= next_os;
			smp <= next_smp;
			nb <= next_nb;
			sh <= next_sh;
			par <= next_par;
			perr <= next_perr;
		end
	end

	// SPI master: clock comes from the write path, not the transmitter enable
	assign m_on = (op_mode_field == usr_pkg::MODE_SPI) && spi_master_sel;
	always_comb
	begin
		next_mbusy = m_busy;
		next_mph = m_ph;
		next_medge = m_edge;
		next_mdiv = m_div;
		next_mtx = m_tx;
		next_mrx = m_rx;
		next_mpush = 1'b0;
		if (!m_busy)
		begin
			if (data_wr && m_on)
			begin
				next_mbusy = 1'b1;
				next_mtx = wr_data;
				next_medge = 4'h0;
				next_mdiv = 8'h00;
				next_mph = 1'b0;
			end
		end
		else if (m_div == baud_div)
		begin
			next_mdiv = 8'h00;
			next_mph = !m_ph;
			next_medge = m_edge + 4'h1;
			if (!m_edge[0] ^ clk_phase_bit)
				next_mrx = {m_rx[6:0], rx_s2};
			else if (m_edge != 4'h0)
				next_mtx = {m_tx[6:0], 1'b0};
			if (m_edge == usr_pkg::SPI_LAST)
			begin
				next_mbusy = 1'b0;
				next_mpush = 1'b1;
			end
		end
		else
			next_mdiv = m_div + 8'h01;
		if (!m_on)
			next_mbusy = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			m_busy <= 1'b0;
			m_ph <= 1'b0;
			m_edge <= 4'h0;
			m_div <= 8'h00;
			m_tx <= usr_pkg::BYTE_RST;
			m_rx <= usr_pkg::BYTE_RST;
			m_push <= 1'b0;
			tx_hold <= usr_pkg::BYTE_RST;
			serial_clock_out <= 1'b0;
			spi_master_out_out <= 1'b0;
			slave_select_n_out <= 1'b1;
			serial_clock_oe <= 1'b0;
			spi_master_out_oe <= 1'b0;
			slave_select_oe <= 1'b0;
			tx_buffer_empty_flag <= 1'b1;
			slave_on <= 1'b0;
			rx_pin_claim <= 1'b0;
		end
		else
		begin
			m_busy <= next_mbusy;
			m_ph <= next_mph;
			m_edge <= next_medge;
			m_div <= next_mdiv;
			m_tx <= next_mtx;
			m_rx <= next_mrx;
			m_push <= next_mpush;
			tx_hold <= data_wr ? wr_data : tx_hold;
			serial_clock_out <= clk_polarity_bit ^ next_mph;
			spi_master_out_out <= next_mtx[7];
			slave_select_n_out <= !next_mbusy;
			serial_clock_oe <= m_on;
			spi_master_out_oe <= m_on;
			slave_select_oe <= m_on && !select_output_ctrl;
			tx_buffer_empty_flag <= !next_mbusy;
			slave_on <= (op_mode_field == usr_pkg::MODE_SPI) && !spi_master_sel && rx_enable_bit;
			rx_pin_claim <= rx_enable_bit;
		end
	end

	// SPI slave on the pin clock; rising link_clk is always the sample edge
	assign link_clk = serial_clock_in ^ clk_polarity_bit ^ clk_phase_bit;
	assign link_clr = slave_select_n_in || !slave_on;
	always_ff @(posedge link_clk or posedge link_clr)
	begin
		if (link_clr)
		begin
			lk_cnt <= 3'h0;
			lk_sh <= 7'h00;
		end
		else
		begin
			lk_cnt <= lk_cnt + 3'h1;
			lk_sh <= {lk_sh[5:0], spi_master_out_in};
		end
	end

	// Word stays put for a whole byte after the toggle, so the core can copy it
	always_ff @(posedge link_clk or posedge reset)
	begin
		if (reset)
		begin
			lk_tog <= 1'b0;
			lk_word <= usr_pkg::BYTE_RST;
		end
		else if (lk_cnt == 3'h7)
		begin
			lk_tog <= !lk_tog;
			lk_word <= {lk_sh, spi_master_out_in};
		end
	end

	// Shift-out edge; phase 0 needs bit 7 before any edge, hence the bypass
	always_ff @(negedge link_clk or posedge link_clr)
	begin
		if (link_clr)
		begin
			lk_tidx <= 3'h0;
			lk_tbit <= 1'b0;
		end
		else
		begin
			lk_tidx <= lk_tidx + 3'h1;
			lk_tbit <= clk_phase_bit ? tx_hold[3'h7 - lk_tidx] : tx_hold[3'h6 - lk_tidx];
		end
	end
	assign spi_master_in_out = (!clk_phase_bit && lk_tidx == 3'h0) ? tx_hold[7] : lk_tbit;
	assign spi_master_in_oe  = slave_on && !slave_select_n_in;

	// Receive buffer: two entries, each word with its own flags
	assign push      = u_push || m_push || (slave_on && (tg_s2 ^ tg_s3));
	assign push_word = u_push ? uart_word : (m_push ? {1'b0, m_rx} : {1'b0, lk_word});
	assign push_fe   = u_push && !bit_val;
	assign push_pe   = u_push && perr;
	assign pop       = data_rd && (cnt != 2'h0);
	always_comb
	begin
		next_rbuf[0] = rbuf[0];
		next_rbuf[1] = rbuf[1];
		next_cnt = cnt;
		next_ovr = pop ? 1'b0 : ovr;
		if (pop)
		begin
			next_rbuf[0] = rbuf[1];
			next_cnt = cnt - 2'h1;
		end
		if (push)
		begin
			if (next_cnt == usr_pkg::BUF_DEPTH)
				next_ovr = 1'b1;
			else
			begin
				next_rbuf[next_cnt[0]] = {push_pe, push_fe, push_word};
				next_cnt = next_cnt + 2'h1;
			end
		end
		if (!rx_enable_bit)
		begin
			next_rbuf[0] = usr_pkg::ENTRY_RST;
			next_rbuf[1] = usr_pkg::ENTRY_RST;
			next_cnt = 2'h0;
			next_ovr = 1'b0;
		end
	end

	// Flags follow the oldest entry on the same edge that the buffer moves
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			rbuf[0] <= usr_pkg::ENTRY_RST;
			rbuf[1] <= usr_pkg::ENTRY_RST;
			cnt <= 2'h0;
			ovr <= 1'b0;
			serial_data_reg <= usr_pkg::BYTE_RST;
			rx_ninth_bit <= 1'b0;
			frame_err_flag <= 1'b0;
			parity_err_flag <= 1'b0;
			overrun_flag <= 1'b0;
			rx_complete_flag <= 1'b0;
			rx_irq <= 1'b0;
		end
		else
		begin
			rbuf[0] <= next_rbuf[0];
			rbuf[1] <= next_rbuf[1];
			cnt <= next_cnt;
			ovr <= next_ovr;
			serial_data_reg <= next_rbuf[0][7:0];
			rx_ninth_bit <= next_rbuf[0][8];
			frame_err_flag <= next_rbuf[0][9];
			parity_err_flag <= next_rbuf[0][10] && parity_enable_bit;
			overrun_flag <= next_ovr;
			rx_complete_flag <= (next_cnt != 2'h0);
			rx_irq <= (next_cnt != 2'h0) && rx_complete_irq_en && global_irq_en;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_flush_on_off: assert property (!rx_enable_bit |=> cnt == 2'h0 && st == usr_pkg::ST_IDLE)
		else $error("receiver not flushed when disabled");
	a_flag_tracks_fill: assert property (##1 rx_complete_flag == (cnt != 2'h0))
		else $error("complete flag disagrees with buffer fill");
	a_irq_gating: assert property (##1 rx_irq == (rx_complete_flag && $past(rx_complete_irq_en) && $past(global_irq_en)))
		else $error("interrupt not gated by flag and enables");
	a_parity_off_zero: assert property (!parity_enable_bit |=> !parity_err_flag)
		else $error("parity error shown with parity off");
	a_depth_two: assert property (cnt <= usr_pkg::BUF_DEPTH)
		else $error("buffer beyond two entries");
	a_overrun_set: assert property (push && cnt == usr_pkg::BUF_DEPTH && !data_rd && rx_enable_bit |=> overrun_flag && cnt == usr_pkg::BUF_DEPTH)
		else $error("overrun not flagged on full buffer");
	a_overrun_read_clr: assert property (pop |=> !overrun_flag)
		else $error("read did not clear overrun");
	a_start_reject: assert property (st == usr_pkg::ST_START && bit_ev && bit_val |=> st == usr_pkg::ST_IDLE)
		else $error("high start samples accepted");
	a_stop_frame_err: assert property (st == usr_pkg::ST_STOP && bit_ev && cnt == 2'h0 && rx_enable_bit |=> ##1 rx_complete_flag && frame_err_flag == !$past(bit_val, 2))
		else $error("stop bit result not stored");
	a_os_range: assert property (st != usr_pkg::ST_IDLE && async_md |-> {1'b0, os_cnt} < os_len)
		else $error("oversample count out of range");
	a_ninth_kept: assert property (u_push && char_size_sel == usr_pkg::SIZE_NINE && cnt == 2'h0 && rx_enable_bit |=> rx_ninth_bit == $past(sh[8]))
		else $error("ninth bit lost");
	a_master_start: assert property (data_wr && m_on && !m_busy |=> m_busy ##1 !slave_select_n_out)
		else $error("master write did not start transfer");

	c_uart_frame: cover property (u_push && !push_fe);
	c_overrun: cover property (push && cnt == usr_pkg::BUF_DEPTH);
	c_master_done: cover property (m_push);
	c_slave_word: cover property (slave_on && (tg_s2 ^ tg_s3));
endmodule
`default_nettype wire

/* usr_peer.sv */
// Purpose: Remote serial peer: async UART transmitter and SPI master for the receiver.
// Assumes: UART bit time is given in core clocks; SPI half period is 80 ns (160 ns link clock).
// Notes: Released data shows the inverse of its last value so a stale bit cannot pass.
`timescale 1ns/10ps
`default_nettype none
module usr_peer (
	input  wire logic core_clk,  // System clock
	input  wire logic miso,      // Reply from the slave
	output logic      uart_line, // Line into the receiver
	output logic      sck,       // Link clock
	output logic      sel_n,     // Select, low
	output logic      mosi       // Data to the slave
);
	// Idle levels: line high, select high, clock still
	initial
	begin
		uart_line = 1'h1;
		sck = 1'h0;
		sel_n = 1'h1;
		mosi = 1'h0;
	end
	// Start bit, then cnt bits LSB first, then idle high
	task automatic send_bits(input logic [11:0] bits, input int cnt, input int per);
		uart_line <= 1'h0;
		repeat (per) @(posedge core_clk);
		for (int i = 0; i < cnt; i++)
		begin
			uart_line <= bits[i];
			repeat (per) @(posedge core_clk);
		end
		uart_line <= 1'h1;
	endtask
	// Clocked frame: data moves on the rising clock, the receiver samples on the falling one
	task automatic sync_send(input logic [11:0] bits, input int cnt);
		#3;
		for (int i = 0; i < cnt; i++)
		begin
			sck = 1'h1;
			uart_line <= bits[i];
			#80;
			sck = 1'h0;
			#80;
		end
	endtask
	// One byte MSB first; the clock takes its idle level before select and toggles only while selected; keep leaves select low
	// Small offset keeps link edges off the core clock edges
	task automatic spi_send(input logic [7:0] d, input logic cpol, input logic cpha, input logic keep,
		output logic [7:0] r);
		#3;
		sck = cpol;
		#80;
		sel_n = 1'h0;
		if (!cpha)
			mosi = d[7];
		#80;
		for (int i = 7; i >= 0; i--)
		begin
			if (cpha)
				mosi = d[i];
			else
				r = {r[6:0], miso};
			sck = ~cpol;
			#80;
			if (cpha)
				r = {r[6:0], miso};
			sck = cpol;
			if (!cpha && i > 0)
				mosi = d[i - 1];
			#80;
		end
		if (!keep)
		begin
			sel_n = 1'h1;
			mosi = ~mosi;
		end
	endtask
endmodule
`default_nettype wire

/* usr_rx_tb.sv */
// Purpose: Self-checking bench for the serial receiver in UART and SPI modes.
// Assumes: baud_div 0 gives one oversample tick per core clock.
// Notes: Two-way pins are resolved here from the drive enables.
`timescale 1ns/10ps
`default_nettype none
module usr_rx_tb;
	logic       core_clk, reset, par_en, par_odd, dbl, cpol, cpha, master, ss_ctrl;
	logic       rx_en, irq_en, gie, data_wr, data_rd;
	logic [1:0] mode;
	logic [2:0] size;
	logic [7:0] baud, wr_data, rdata, reply;
	logic       sck_out, sck_oe, ss_out, ss_oe, mosi_out, mosi_oe, claim, ninth, fe, pe, ovr, rxc, irq, tbe;
	logic       p_line, p_sck, p_ss, p_mosi, sck_w, ss_w, mosi_w, rx_w, miso_out, miso_oe, miso_w;
	int         bad_count, checks;

	// Wire levels from all drivers
	assign sck_w  = sck_oe ? sck_out : p_sck;
	assign ss_w   = ss_oe ? ss_out : p_ss;
	assign mosi_w = mosi_oe ? mosi_out : p_mosi;
	assign miso_w = miso_oe ? miso_out : 1'h1;
	// Master loopback: its own data out feeds its data in
	assign rx_w   = mosi_oe ? mosi_out : p_line;

	usr_peer peer (.core_clk(core_clk), .miso(miso_w), .uart_line(p_line), .sck(p_sck), .sel_n(p_ss),
		.mosi(p_mosi));

	usr_rx dut (.core_clk(core_clk), .reset(reset), .op_mode_field(mode), .char_size_sel(size),
		.parity_enable_bit(par_en), .parity_odd_sel(par_odd), .double_speed_sel(dbl),
		.clk_polarity_bit(cpol), .clk_phase_bit(cpha), .spi_master_sel(master),
		.select_output_ctrl(ss_ctrl), .rx_enable_bit(rx_en), .rx_complete_irq_en(irq_en),
		.global_irq_en(gie), .baud_div(baud), .data_wr(data_wr), .wr_data(wr_data), .data_rd(data_rd),
		.serial_in_pin(rx_w), .serial_clock_in(sck_w), .serial_clock_out(sck_out),
		.serial_clock_oe(sck_oe), .slave_select_n_in(ss_w), .slave_select_n_out(ss_out),
		.slave_select_oe(ss_oe), .spi_master_out_in(mosi_w), .spi_master_out_out(mosi_out),
		.spi_master_out_oe(mosi_oe), .spi_master_in_out(miso_out), .spi_master_in_oe(miso_oe),
		.rx_pin_claim(claim),
		.serial_data_reg(rdata), .rx_ninth_bit(ninth), .frame_err_flag(fe), .parity_err_flag(pe),
		.overrun_flag(ovr), .rx_complete_flag(rxc), .rx_irq(irq), .tx_buffer_empty_flag(tbe));

	// 100 MHz core clock
	always #5 core_clk = ~core_clk;

	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic stop_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Bounded wait for unread data; a hang ends the run
	task automatic wait_rxc;
		int i;
		i = 0;
		while (rxc !== 1'h1 && i < 5000)
		begin
			tick(1);
			i++;
		end
		if (i == 5000)
		begin
			bad_count++;
			stop_test();
		end
	endtask

	// Flags and ninth bit are read before the pop, since the pop moves the head
	task automatic rd_chk(input logic [7:0] d, input logic n9, input logic f, input logic p);
		@(negedge core_clk);
		chk("ninth", n9, ninth);
		chk("frame_err", f, fe);
		chk("parity_err", p, pe);
		chk("data", d, rdata);
		@(posedge core_clk);
		data_rd <= 1'h1;
		@(posedge core_clk);
		data_rd <= 1'h0;
	endtask

	// Frame of n data bits, optional parity, one stop bit of the given level
	task automatic frame(input logic [8:0] d, input int n, input logic use_par, input logic pbit,
		input logic stopb, input int per);
		logic [11:0] bits;
		int          k;
		bits = {3'h0, d};
		k = n;
		if (use_par)
		begin
			bits[k] = pbit;
			k++;
		end
		bits[k] = stopb;
		peer.send_bits(bits, k + 1, per);
		tick(per);
	endtask

	// Main sequence
	initial
	begin
		logic [8:0] d;
		logic [8:0] mask;
		core_clk = 1'h0;
		reset = 1'h1;
		{mode, size, par_en, par_odd, dbl, cpol, cpha, master} = {2'h0, 3'h3, 6'h00};
		{ss_ctrl, rx_en, irq_en, gie, data_wr, data_rd} = 6'h3c;
		baud = 8'h00;
		wr_data = 8'h00;
		bad_count = 0;
		checks = 0;
		tick(20);
		reset <= 1'h0;
		tick(2);
		@(negedge core_clk);
		chk("rx_complete", 9'h0, rxc);
		chk("tx_empty", 9'h1, tbe);
		chk("claim", 9'h1, claim);
		// Short low glitch must not start a frame
		peer.send_bits(12'h000, 0, 4);
		tick(300);
		chk("rx_complete", 9'h0, rxc);
		// Plain frame and the interrupt enables
		frame(9'h0a5, 8, 1'h0, 1'h0, 1'h1, 16);
		wait_rxc();
		for (int k = 0; k < 4; k++)
		begin
			irq_en <= k[0];
			gie <= k[1];
			tick(2);
			@(negedge core_clk);
			chk("irq", {8'h0, k == 3}, irq);
		end
		rd_chk(8'ha5, 1'h0, 1'h0, 1'h0);
		@(negedge core_clk);
		chk("rx_complete", 9'h0, rxc);
		// Three words into a two-entry buffer
		frame(9'h0a1, 8, 1'h0, 1'h0, 1'h1, 16);
		frame(9'h0a2, 8, 1'h0, 1'h0, 1'h1, 16);
		frame(9'h0a3, 8, 1'h0, 1'h0, 1'h1, 16);
		@(negedge core_clk);
		chk("overrun", 9'h1, ovr);
		rd_chk(8'ha1, 1'h0, 1'h0, 1'h0);
		@(negedge core_clk);
		chk("overrun", 9'h0, ovr);
		rd_chk(8'ha2, 1'h0, 1'h0, 1'h0);
		@(negedge core_clk);
		chk("rx_complete", 9'h0, rxc);
		// Even and odd parity, good and bad
		for (int k = 0; k < 4; k++)
		begin
			par_en <= 1'h1;
			par_odd <= k[1];
			tick(1);
			d = 9'h037 + 9'(k);
			frame(d, 8, 1'h1, ^d[7:0] ^ k[1] ^ k[0], 1'h1, 16);
			rd_chk(d[7:0], 1'h0, 1'h0, k[0]);
		end
		// Odd parity still selected, so a low parity bit is a stored error
		frame(9'h0e7, 8, 1'h1, 1'h0, 1'h1, 16);
		@(negedge core_clk);
		chk("parity_err", 9'h1, pe);
		tick(1);
		par_en <= 1'h0;
		tick(1);
		@(negedge core_clk);
		chk("parity_err", 9'h0, pe);
		rd_chk(8'he7, 1'h0, 1'h0, 1'h0);
		// Low stop bit, then a clean frame right after
		frame(9'h05a, 8, 1'h0, 1'h0, 1'h0, 16);
		frame(9'h0c3, 8, 1'h0, 1'h0, 1'h1, 16);
		rd_chk(8'h5a, 1'h0, 1'h1, 1'h0);
		rd_chk(8'hc3, 1'h0, 1'h0, 1'h0);
		// Every character size
		for (int k = 0; k < 5; k++)
		begin
			size <= (k < 4) ? 3'(k) : usr_pkg::SIZE_NINE;
			tick(1);
			mask = (9'h001 << ((k < 4) ? k + 5 : 9)) - 9'h001;
			d = 9'h1b5 & mask;
			frame(d, (k < 4) ? k + 5 : 9, 1'h0, 1'h0, 1'h1, 16);
			rd_chk(d[7:0], d[8], 1'h0, 1'h0);
		end
		// Double speed: eight ticks per bit
		size <= 3'h3;
		dbl <= 1'h1;
		tick(1);
		frame(9'h069, 8, 1'h0, 1'h0, 1'h1, 8);
		rd_chk(8'h69, 1'h0, 1'h0, 1'h0);
		dbl <= 1'h0;
		// Disable in mid-frame with a word already buffered
		frame(9'h011, 8, 1'h0, 1'h0, 1'h1, 16);
		fork
			frame(9'h022, 8, 1'h0, 1'h0, 1'h1, 16);
			begin
				tick(60);
				rx_en <= 1'h0;
			end
		join
		@(negedge core_clk);
		chk("rx_complete", 9'h0, rxc);
		chk("claim", 9'h0, claim);
		chk("data", 9'h0, rdata);
		rx_en <= 1'h1;
		tick(2);
		frame(9'h033, 8, 1'h0, 1'h0, 1'h1, 16);
		rd_chk(8'h33, 1'h0, 1'h0, 1'h0);
		// Clocked UART frame: start, eight data bits, stop
		mode <= 2'h1;
		tick(2);
		peer.sync_send({3'h7, 8'h4b, 1'h0}, 10);
		wait_rxc();
		rd_chk(8'h4b, 1'h0, 1'h0, 1'h0);
		// SPI slave in all four clock formats; the written byte is the reply
		mode <= usr_pkg::MODE_SPI;
		data_wr <= 1'h1;
		wr_data <= 8'h96;
		tick(1);
		data_wr <= 1'h0;
		for (int k = 0; k < 4; k++)
		begin
			cpol <= k[1];
			cpha <= k[0];
			tick(2);
			peer.spi_send(8'h5c ^ 8'(k), k[1], k[0], 1'h0, reply);
			chk("reply", 9'h096, reply);
			wait_rxc();
			rd_chk(8'h5c ^ 8'(k), 1'h0, 1'h0, 1'h0);
		end
		// Phase 1: two bytes under one select
		peer.spi_send(8'h71, 1'h1, 1'h1, 1'h1, reply);
		peer.spi_send(8'h72, 1'h1, 1'h1, 1'h0, reply);
		chk("reply", 9'h096, reply);
		wait_rxc();
		rd_chk(8'h71, 1'h0, 1'h0, 1'h0);
		rd_chk(8'h72, 1'h0, 1'h0, 1'h0);
		// SPI master started by a write; its data out loops back to its data in
		{cpol, cpha} <= 2'h0;
		master <= 1'h1;
		ss_ctrl <= 1'h0;
		baud <= 8'h02;
		tick(2);
		data_wr <= 1'h1;
		wr_data <= 8'h3c;
		tick(1);
		data_wr <= 1'h0;
		tick(2);
		@(negedge core_clk);
		chk("tx_empty", 9'h0, tbe);
		chk("select_out", 9'h0, ss_out);
		chk("select_oe", 9'h1, ss_oe);
		chk("clock_oe", 9'h1, sck_oe);
		wait_rxc();
		rd_chk(8'h3c, 1'h0, 1'h0, 1'h0);
		stop_test();
	end
endmodule
`default_nettype wire
